// file: hdl/tcd_engine.v
// three-channel memory transfer engine with apb registers and event triggers
// How it works
// - three independent channels; channels 0 and 1 full, channel 2 basic
// - repeat, fill and gather only on full channels; basic repeats only through auto re-enable
// - element sizes byte, half, word; read and write sizes may differ
// - every channel moves 128-bit elements and can re-enable itself
// - 17-bit counter up to 131071 elements (0 runs 131072), decremented once per element moved
// - programmable priority, arbitration per element lets higher channels preempt
// - full channels flag early at half count for ping-pong refills
// - completion of one channel can trigger a configured other channel
// - stride mode advances source address by a programmable step
// - trigger select: 0 software, 1-2 subscribers, 3-14 serial, 15 converter
// - a routed event starts the transfer of the waiting channel
// - route selector: 0 none, 1-5 point to point, 6-7 splitter
`timescale 1ns/1ps
`include "tcd_map.vh"
module tcd_engine (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire [7:1]  gen_evt,
   input  wire [11:0] serial_pub,
   input  wire        conv_evt,
   output reg         mem_req,
   output reg         mem_we,
   output reg  [1:0]  mem_size,
   output reg  [31:0] mem_addr,
   output reg  [31:0] mem_wdata,
   input  wire        mem_ack,
   input  wire [31:0] mem_rdata
);
   localparam ST_IDLE = 2'h0;
   localparam ST_RD   = 2'h1;
   localparam ST_WR   = 2'h2;
   localparam ST_UPD  = 2'h3;

   reg  [31:0] ctl  [0:2];
   reg  [31:0] src  [0:2];
   reg  [31:0] dst  [0:2];
   reg  [16:0] cnt  [0:2];
   reg  [31:0] isrc [0:2];
   reg  [31:0] idst [0:2];
   reg  [16:0] icnt [0:2];
   reg  [2:0]  pend;
   reg  [2:0]  done;
   reg  [2:0]  early;
   reg  [5:0]  prio;
   reg  [2:0]  route_a;
   reg  [2:0]  route_b;
   reg  [1:0]  state;
   reg  [1:0]  cur;
   reg  [1:0]  beat;
   reg  [1:0]  wsz;
   reg         push_v;
   reg  [31:0] push_d;
   reg  [2:0]  sel_ch;
   reg  [1:0]  best;
   reg  [1:0]  best_p;
   reg         found;
   reg  [31:0] rd_val;
   reg         rd_err;
   integer     i;
   integer     j;

   wire        f_in_ready;
   wire        f_out_valid;
   wire [31:0] f_out_data;
   wire        f_pop;
   wire        sub_a;
   wire        sub_b;
   wire [15:0] trig_vec;
   wire [2:0]  trig_hit;
   wire [2:0]  req;
   wire        apb_wr;
   wire        apb_setup;
   wire [1:0]  a_ch;
   wire [3:0]  a_off;
   wire        a_chreg;
   wire [31:0] cc;
   wire        cfull;
   wire [1:0]  ssz;
   wire [1:0]  dsz;
   wire        quad;
   wire        last_beat;
   wire [31:0] sstep;
   wire [31:0] dstep;
   wire [16:0] cnt_next;
   wire        blk_end;

   // generic route decode; a splitter channel may feed both subscribers
   assign sub_a = (route_a != `TCD_ROUTE_NONE) & gen_evt[route_a];
   assign sub_b = (route_b != `TCD_ROUTE_NONE) & gen_evt[route_b];
   assign trig_vec = {conv_evt, serial_pub, sub_b, sub_a, 1'b0};

   genvar g;
   generate
      for (g = 0; g < `TCD_NCH; g = g + 1)
      begin : g_ch
         // software trigger goes through the swtrig register, not this vector
         assign trig_hit[g] = ctl[g][`TCD_F_EN]
                            & trig_vec[ctl[g][`TCD_F_TSEL_HI:`TCD_F_TSEL_LO]];
         // block mode keeps requesting after one trigger until the count ends
         assign req[g] = ctl[g][`TCD_F_EN] & (pend[g]
                       | (ctl[g][`TCD_F_BLOCK] & (cnt[g] != icnt[g])));
      end
   endgenerate

   // lowest priority value wins, ties go to the lower channel number
   always @*
   begin
      best   = 2'h0;
      best_p = 2'h3;
      found  = 1'b0;
      sel_ch = 3'h0;
      for (j = 0; j < `TCD_NCH; j = j + 1)
      begin
         if (req[j] && (!found || prio[2*j +: 2] < best_p))
         begin
            found  = 1'b1;
            best   = j[1:0];
            best_p = prio[2*j +: 2];
         end
      end
      if (found)
         sel_ch[best] = 1'b1;
   end

   assign cc        = ctl[cur];
   assign cfull     = (cur < `TCD_FULL_CH);
   assign ssz       = cc[`TCD_F_SSZ_HI:`TCD_F_SSZ_LO];
   assign dsz       = cc[`TCD_F_DSZ_HI:`TCD_F_DSZ_LO];
   assign quad      = (ssz == `TCD_SZ_QUAD) & (dsz == `TCD_SZ_QUAD);
   assign last_beat = !quad | (beat == `TCD_QUAD_BEATS);
   assign sstep     = (cfull & cc[`TCD_F_FILL]) ? 32'h0 :
                      cc[`TCD_F_STRIDE] ? {24'h0, cc[`TCD_F_STEP_HI:`TCD_F_STEP_LO]} :
                      (32'h1 << ssz);
   assign dstep     = (cfull & cc[`TCD_F_GATHER]) ? 32'h0 : (32'h1 << dsz);
   assign cnt_next  = cnt[cur] - 1'b1;
   assign blk_end   = (cnt_next == {`TCD_CNT_W{1'b0}});
   assign f_pop     = (state == ST_WR) & !mem_req & f_out_valid;

   assign apb_setup = psel & !penable;
   assign apb_wr    = psel & penable & pready & pwrite;
   assign a_ch      = paddr[5:4];
   assign a_off     = paddr[3:0];
   assign a_chreg   = (paddr < `TCD_ADDR_PRIO);

   // read mux; cnt reads the live remaining count
   always @*
   begin
      rd_val = 32'h0;
      rd_err = 1'b0;
      if (paddr[1:0] != 2'h0)
         rd_err = 1'b1;
      else if (a_chreg)
      begin
         case (a_off)
            `TCD_OFF_CTL: rd_val = ctl[a_ch];
            `TCD_OFF_SRC: rd_val = src[a_ch];
            `TCD_OFF_DST: rd_val = dst[a_ch];
            `TCD_OFF_CNT: rd_val = {15'h0, cnt[a_ch]};
            default:      rd_err = 1'b1;
         endcase
      end
      else
      begin
         case (paddr)
            `TCD_ADDR_PRIO:   rd_val = {26'h0, prio};
            `TCD_ADDR_STAT:   rd_val = {21'h0, cur, (state != ST_IDLE), 1'b0,
                                        early, 1'b0, done};
            `TCD_ADDR_SWTRIG: rd_val = {29'h0, pend};
            `TCD_ADDR_ROUTE:  rd_val = {24'h0, route_b >= `TCD_ROUTE_SPLIT, route_b,
                                        route_a >= `TCD_ROUTE_SPLIT, route_a};
            default:          rd_err = 1'b1;
         endcase
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= 32'h0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= apb_setup;
         prdata  <= (apb_setup & !pwrite) ? rd_val : 32'h0;
         pslverr <= apb_setup & rd_err;
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (i = 0; i < `TCD_NCH; i = i + 1)
         begin
            ctl[i]  <= `TCD_CTL_RST;
            src[i]  <= 32'h0;
            dst[i]  <= 32'h0;
            cnt[i]  <= {`TCD_CNT_W{1'b0}};
            isrc[i] <= 32'h0;
            idst[i] <= 32'h0;
            icnt[i] <= {`TCD_CNT_W{1'b0}};
         end
         pend      <= 3'h0;
         done      <= 3'h0;
         early     <= 3'h0;
         prio      <= `TCD_PRIO_RST;
         route_a   <= `TCD_ROUTE_NONE;
         route_b   <= `TCD_ROUTE_NONE;
         state     <= ST_IDLE;
         cur       <= 2'h0;
         beat      <= 2'h0;
         wsz       <= 2'h0;
         push_v    <= 1'b0;
         push_d    <= 32'h0;
         mem_req   <= 1'b0;
         mem_we    <= 1'b0;
         mem_size  <= 2'h0;
         mem_addr  <= 32'h0;
         mem_wdata <= 32'h0;
      end
      else
      begin
         // software side first so that hardware events below win the same cycle
         if (apb_wr)
         begin
            if (a_chreg && paddr[1:0] == 2'h0)
            begin
               case (a_off)
                  `TCD_OFF_CTL: ctl[a_ch] <= pwdata;
                  `TCD_OFF_SRC:
                  begin
                     src[a_ch]  <= pwdata;
                     isrc[a_ch] <= pwdata;
                  end
                  `TCD_OFF_DST:
                  begin
                     dst[a_ch]  <= pwdata;
                     idst[a_ch] <= pwdata;
                  end
                  `TCD_OFF_CNT:
                  begin
                     cnt[a_ch]  <= pwdata[16:0];
                     icnt[a_ch] <= pwdata[16:0];
                  end
                  default: ;
               endcase
            end
            case (paddr)
               `TCD_ADDR_PRIO: prio <= pwdata[5:0];
               `TCD_ADDR_STAT:
               begin
                  done  <= done & ~pwdata[2:0];
                  early <= early & ~pwdata[6:4];
               end
               `TCD_ADDR_ROUTE:
               begin
                  route_a <= pwdata[2:0];
                  route_b <= pwdata[6:4];
               end
               default: ;
            endcase
         end
         push_v <= 1'b0;
         case (state)
            ST_IDLE:
            begin
               beat <= 2'h0;
               if (found)
               begin
                  // one element per grant so a higher channel can cut in
                  cur      <= best;
                  state    <= ST_RD;
                  pend     <= pend & ~sel_ch;
                  mem_req  <= 1'b1;
                  mem_we   <= 1'b0;
                  mem_addr <= src[best];
                  mem_size <= (ctl[best][`TCD_F_SSZ_HI:`TCD_F_SSZ_LO] == `TCD_SZ_QUAD)
                              ? `TCD_SZ_WORD : ctl[best][`TCD_F_SSZ_HI:`TCD_F_SSZ_LO];
                  wsz      <= (ctl[best][`TCD_F_DSZ_HI:`TCD_F_DSZ_LO] == `TCD_SZ_QUAD)
                              ? `TCD_SZ_WORD : ctl[best][`TCD_F_DSZ_HI:`TCD_F_DSZ_LO];
               end
            end
            ST_RD:
            begin
               // beats after the first wait for fifo room; the first read is issued from idle without a check
               if (mem_req && mem_ack)
               begin
                  mem_req <= 1'b0;
                  push_v  <= 1'b1;
                  push_d  <= mem_rdata;
                  if (last_beat)
                  begin
                     state <= ST_WR;
                     beat  <= 2'h0;
                  end
                  else
                     beat <= beat + 1'b1;
               end
               else if (!mem_req && !push_v && f_in_ready)
               begin
                  mem_req  <= 1'b1;
                  mem_addr <= src[cur] + {28'h0, beat, 2'h0};
               end
            end
            ST_WR:
            begin
               if (mem_req && mem_ack)
               begin
                  mem_req <= 1'b0;
                  if (last_beat)
                     state <= ST_UPD;
                  else
                     beat <= beat + 1'b1;
               end
               else if (f_pop)
               begin
                  // mixed sizes: narrow data is zero extended, wide data truncated
                  mem_req   <= 1'b1;
                  mem_we    <= 1'b1;
                  mem_size  <= wsz;
                  mem_addr  <= dst[cur] + {28'h0, beat, 2'h0};
                  mem_wdata <= (wsz == `TCD_SZ_BYTE) ? {24'h0, f_out_data[7:0]} :
                               (wsz == `TCD_SZ_HALF) ? {16'h0, f_out_data[15:0]} :
                               f_out_data;
               end
            end
            ST_UPD:
            begin
               state  <= ST_IDLE;
               mem_we <= 1'b0;
               if (cfull && cc[`TCD_F_EARLY] && cnt_next == (icnt[cur] >> 1))
                  early[cur] <= 1'b1;
               if (blk_end)
               begin
                  done[cur] <= 1'b1;
                  for (i = 0; i < `TCD_NCH; i = i + 1)
                  begin
                     if (ctl[i][`TCD_F_CAS_HI:`TCD_F_CAS_LO] == cur + 2'h1
                         && ctl[i][`TCD_F_EN])
                        pend[i] <= 1'b1;
                  end
                  if ((cfull && cc[`TCD_F_REPEAT]) || cc[`TCD_F_AUTO])
                  begin
                     cnt[cur] <= icnt[cur];
                     src[cur] <= isrc[cur];
                     dst[cur] <= idst[cur];
                  end
                  else
                  begin
                     cnt[cur] <= cnt_next;
                     ctl[cur][`TCD_F_EN] <= 1'b0;
                  end
               end
               else
               begin
                  cnt[cur] <= cnt_next;
                  src[cur] <= src[cur] + (quad ? 32'h10 : sstep);
                  dst[cur] <= dst[cur] + (quad ? 32'h10 : dstep);
               end
            end
            default: state <= ST_IDLE;
         endcase
         // sets come after the grant clear so a trigger in the grant cycle is kept
         for (i = 0; i < `TCD_NCH; i = i + 1)
         begin
            if (trig_hit[i])
               pend[i] <= 1'b1;
            if (apb_wr && paddr == `TCD_ADDR_SWTRIG && pwdata[i] && ctl[i][`TCD_F_EN]
                && ctl[i][`TCD_F_TSEL_HI:`TCD_F_TSEL_LO] == `TCD_TSEL_SW)
               pend[i] <= 1'b1;
         end
      end
   end

   tcd_fifo #(
      .W  (`TCD_FIFO_W),
      .D  (`TCD_FIFO_D),
      .AW (`TCD_FIFO_AW)
   ) u_fifo (
      .pclk      (pclk),
      .presetn   (presetn),
      .in_valid  (push_v),
      .in_data   (push_d),
      .in_ready  (f_in_ready),
      .out_valid (f_out_valid),
      .out_data  (f_out_data),
      .out_ready (f_pop)
   );
endmodule // tcd_engine

// file: hdl/tcd_fifo.v
// synchronous valid/ready fifo that sits between the read and write halves of the engine
`timescale 1ns/1ps
module tcd_fifo #(
   parameter W  = 32,
   parameter D  = 16,
   parameter AW = 4
) (
   input  wire          pclk,
   input  wire          presetn,
   input  wire          in_valid,
   input  wire [W-1:0]  in_data,
   output wire          in_ready,
   output wire          out_valid,
   output wire [W-1:0]  out_data,
   input  wire          out_ready
);
   reg [W-1:0]  mem [0:D-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [AW:0]   level;
   wire         push;
   wire         pop;

   assign in_ready  = (level != D[AW:0]);
   assign out_valid = (level != {(AW+1){1'b0}});
   assign out_data  = mem[rd_ptr];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always @(posedge pclk)
   begin
      if (push)
         mem[wr_ptr] <= in_data;
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         level  <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
            wr_ptr <= wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= rd_ptr + 1'b1;
         if (push & !pop)
            level <= level + 1'b1;
         else if (pop & !push)
            level <= level - 1'b1;
      end
   end
endmodule // tcd_fifo

// file: hdl/tcd_map.vh
// register map, field positions and constants of the three-channel transfer engine
`ifndef TCD_MAP_VH
`define TCD_MAP_VH
`define TCD_NCH          3
`define TCD_FULL_CH      2
`define TCD_CH_STRIDE    8'h10
`define TCD_OFF_CTL      4'h0
`define TCD_OFF_SRC      4'h4
`define TCD_OFF_DST      4'h8
`define TCD_OFF_CNT      4'hC
`define TCD_ADDR_PRIO    8'h30
`define TCD_ADDR_STAT    8'h34
`define TCD_ADDR_SWTRIG  8'h38
`define TCD_ADDR_ROUTE   8'h3C
`define TCD_CTL_RST      32'h0000_0000
`define TCD_PRIO_RST     6'h24
`define TCD_F_EN         0
`define TCD_F_REPEAT     1
`define TCD_F_FILL       2
`define TCD_F_GATHER     3
`define TCD_F_SSZ_LO     4
`define TCD_F_SSZ_HI     5
`define TCD_F_DSZ_LO     6
`define TCD_F_DSZ_HI     7
`define TCD_F_TSEL_LO    8
`define TCD_F_TSEL_HI    11
`define TCD_F_AUTO       12
`define TCD_F_CAS_LO     13
`define TCD_F_CAS_HI     14
`define TCD_F_EARLY      15
`define TCD_F_BLOCK      16
`define TCD_F_STRIDE     17
`define TCD_F_STEP_LO    24
`define TCD_F_STEP_HI    31
`define TCD_CNT_W        17
`define TCD_SZ_BYTE      2'h0
`define TCD_SZ_HALF      2'h1
`define TCD_SZ_WORD      2'h2
`define TCD_SZ_QUAD      2'h3
`define TCD_QUAD_BEATS   2'h3
`define TCD_TSEL_SW      4'h0
`define TCD_TSEL_SUB_A   4'h1
`define TCD_TSEL_SUB_B   4'h2
`define TCD_TSEL_CONV    4'hF
`define TCD_ROUTE_NONE   3'h0
`define TCD_ROUTE_SPLIT  3'h6
`define TCD_FIFO_W       32
`define TCD_FIFO_D       16
`define TCD_FIFO_AW      4
`endif

// file: test/tb.sv
// self-checking bench for the three-channel transfer engine
`timescale 1ns/1ps
`include "tcd_map.vh"
module tb;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        conv_evt, mem_req, mem_we, mem_ack;
   logic [7:0]  paddr;
   logic [7:1]  gen_evt;
   logic [11:0] serial_pub;
   logic [1:0]  mem_size;
   logic [31:0] pwdata, prdata, mem_addr, mem_wdata, mem_rdata, seed, src;
   logic [32:0] q_apb[$];
   logic [63:0] q_mem[$];
   int          n_mismatch = 0;
   int          compares = 0;
   tcd_engine dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .gen_evt(gen_evt), .serial_pub(serial_pub), .conv_evt(conv_evt),
      .mem_req(mem_req), .mem_we(mem_we), .mem_size(mem_size), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
   tcd_mem_model u_mem (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_we(mem_we),
      .mem_size(mem_size), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic logic [31:0] pat(input logic [31:0] a, input logic [1:0] sz);
      logic [31:0] v;
      v = a ^ {a[15:0], 16'h5AC3};
      return sz == `TCD_SZ_BYTE ? {24'h0, v[7:0]} : sz == `TCD_SZ_HALF ? {16'h0, v[15:0]} : v;
   endfunction
   task chk(input logic [63:0] g, input logic [63:0] e);
      compares++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task final_report;
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      q_apb.push_back(e);
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 33'h0);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, {1'b0, e});
   endtask
   // enable goes in last so the channel never runs on half-written pointers
   task setch(input logic [7:0] b, input logic [31:0] ctl, s, d, n);
      wr(b + 8'h4, s);
      wr(b + 8'h8, d);
      wr(b + 8'hC, n);
      wr(b, ctl);
   endtask
   task pulse(input int n);
      @(posedge pclk);
      {conv_evt, gen_evt, serial_pub} <= 20'h1 << n;
      @(posedge pclk);
      {conv_evt, gen_evt, serial_pub} <= 20'h0;
   endtask
   task drain;
      for (int i = 0; i < 400 && q_mem.size() != 0; i++)
         @(posedge pclk);
      repeat (4) @(posedge pclk);
      chk(64'(q_mem.size()), 64'h0);
   endtask
   always @(posedge pclk)
   begin
      if (psel && penable && pready === 1'b1)
         chk({pslverr, prdata}, q_apb.size() ? q_apb.pop_front() : '1);
      if (mem_req && mem_we && mem_ack)
         chk({mem_addr, mem_wdata}, q_mem.size() ? q_mem.pop_front() : '1);
   end
   initial
   begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   initial
   begin
      repeat (20000) @(posedge pclk);
      n_mismatch++;
      final_report;
   end
   initial
   begin
      {presetn, psel, penable, pwrite, conv_evt, gen_evt, serial_pub} = '0;
      paddr = 8'h0;
      pwdata = 32'h0;
      seed = 32'h07626639;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd(`TCD_ADDR_PRIO, `TCD_PRIO_RST);
      rd(8'h10, `TCD_CTL_RST);
      apb(1'b0, 8'h40, 32'h0, {1'b1, 32'h0});
      // misaligned write lands next to the priority word: must not alter it
      apb(1'b1, 8'h31, 32'hFFFF_FFFF, {1'b1, 32'h0});
      rd(`TCD_ADDR_PRIO, `TCD_PRIO_RST);
      setch(8'h00, 32'h1, 32'h100, 32'h200, 32'h2);
      for (int i = 0; i < 2; i++)
      begin
         q_mem.push_back({32'h200 + i, pat(32'h100 + i, `TCD_SZ_BYTE)});
         wr(`TCD_ADDR_SWTRIG, 32'h1);
         drain;
         rd(8'h0C, 32'(1 - i));
      end
      rd(`TCD_ADDR_STAT, 32'h1);
      rd(8'h00, 32'h0);
      seed = xs(seed);
      src = {16'h0, seed[15:2], 2'b00};
      setch(8'h10, 32'h0001_0FA1, src, 32'h400, 32'h3);
      for (int i = 0; i < 3; i++)
         q_mem.push_back({32'h400 + 4 * i, pat(src + 4 * i, `TCD_SZ_WORD)});
      pulse(19);
      drain;
      for (int r = 0; r < 8; r++)
      begin
         wr(`TCD_ADDR_ROUTE, 32'(r * 17));
         rd(`TCD_ADDR_ROUTE, 32'(r * 17) | (r > 5 ? 32'h88 : 32'h0));
      end
      wr(`TCD_ADDR_ROUTE, 32'h6);
      seed = xs(seed);
      src = {16'h0, seed[15:1], 1'b0};
      setch(8'h20, 32'h151, src, 32'h500, 32'h1);
      pulse(16);
      repeat (20) @(posedge pclk);
      q_mem.push_back({32'h500, pat(src, `TCD_SZ_HALF)});
      pulse(17);
      drain;
      for (int k = 0; k < 12; k++)
      begin
         seed = xs(seed);
         setch(8'h00, 32'h1 | 32'((k + 3) << 8), seed, 32'h600 + k, 32'h1);
         pulse((k + 1) % 12);
         repeat (20) @(posedge pclk);
         q_mem.push_back({32'h600 + k, pat(seed, `TCD_SZ_BYTE)});
         pulse(k);
         drain;
      end
      seed = xs(seed);
      src = {16'h0, seed[15:2], 2'b00};
      setch(8'h20, 32'h20F1, src ^ 32'h40, 32'h800, 32'h1);
      setch(8'h00, 32'h0803_80A1, src, 32'h700, 32'h2);
      for (int i = 0; i < 2; i++)
         q_mem.push_back({32'h700 + 4 * i, pat(src + 8 * i, `TCD_SZ_WORD)});
      for (int i = 0; i < 4; i++)
         q_mem.push_back({32'h800 + 4 * i, pat((src ^ 32'h40) + 4 * i, `TCD_SZ_WORD)});
      wr(`TCD_ADDR_SWTRIG, 32'h1);
      drain;
      rd(`TCD_ADDR_STAT, 32'h417);
      wr(`TCD_ADDR_STAT, 32'h77);
      rd(`TCD_ADDR_STAT, 32'h400);
      setch(8'h10, 32'h0001_00A7, src, 32'h900, 32'h2);
      for (int i = 0; i < 2; i++)
         q_mem.push_back({32'h900 + 4 * i, pat(src, `TCD_SZ_WORD)});
      wr(`TCD_ADDR_SWTRIG, 32'h2);
      drain;
      rd(8'h10, 32'h0001_00A7);
      rd(8'h1C, 32'h2);
      wr(`TCD_ADDR_PRIO, 32'h12);
      setch(8'h00, 32'h1, src, 32'hA00, 32'h1);
      setch(8'h10, 32'h1, src + 1, 32'hB00, 32'h1);
      q_mem.push_back({32'hB00, pat(src + 1, `TCD_SZ_BYTE)});
      q_mem.push_back({32'hA00, pat(src, `TCD_SZ_BYTE)});
      wr(`TCD_ADDR_SWTRIG, 32'h3);
      drain;
      chk(64'(q_apb.size()), 64'h0);
      final_report;
   end
endmodule // tb

// file: test/tcd_engine_props.sv
// port-level assertions for the three-channel transfer engine
`timescale 1ns/1ps
module tcd_engine_props (
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire        mem_req,
   input wire        mem_we,
   input wire [1:0]  mem_size,
   input wire [31:0] mem_addr,
   input wire [31:0] mem_wdata,
   input wire        mem_ack
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_wait;
      mem_req && !mem_ack;
   endsequence
   sequence s_done;
      mem_req && mem_ack;
   endsequence
   AST_SETUP_READY:
      assert property (s_setup |=> pready) else $error("no ready after setup");
   AST_NO_EXTRA_READY:
      assert property (!(psel && !penable) |=> !pready) else $error("stray ready");
   AST_RDATA_IDLE:
      assert property (!pready |-> prdata == 32'h0) else $error("read data not zero");
   AST_ERR_WITH_READY:
      assert property (pslverr |-> pready) else $error("error without ready");
   AST_REQ_HOLD:
      assert property (s_wait |=> mem_req && $stable(mem_addr) && $stable(mem_we)
         && $stable(mem_size) && $stable(mem_wdata)) else $error("request changed");
   AST_REQ_DROP:
      assert property (s_done |=> !mem_req) else $error("request held after ack");
   AST_SIZE_LEGAL:
      assert property (mem_req |-> mem_size != 2'h3) else $error("illegal beat size");
   AST_BYTE_ZEXT:
      assert property (mem_req && mem_we && mem_size == 2'h0 |-> mem_wdata[31:8] == 24'h0)
         else $error("byte data not extended");
   AST_HALF_ZEXT:
      assert property (mem_req && mem_we && mem_size == 2'h1 |-> mem_wdata[31:16] == 16'h0)
         else $error("half data not extended");
endmodule // tcd_engine_props
bind tcd_engine tcd_engine_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
   .mem_we(mem_we), .mem_size(mem_size), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
   .mem_ack(mem_ack));

// file: test/tcd_mem_model.sv
// memory-side partner that answers each engine request after a varying delay
`timescale 1ns/1ps
module tcd_mem_model (
   input  wire         pclk,
   input  wire         presetn,
   input  wire         mem_req,
   input  wire         mem_we,
   input  wire  [1:0]  mem_size,
   input  wire  [31:0] mem_addr,
   output logic        mem_ack,
   output logic [31:0] mem_rdata
);
   logic [7:0]  lfsr;
   logic [1:0]  wait_n;
   logic [31:0] v;
   assign v = mem_addr ^ {mem_addr[15:0], 16'h5AC3};
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mem_ack <= 1'b0;
         wait_n <= 2'h0;
         lfsr <= 8'h5B;
         mem_rdata <= 32'h0;
      end
      else
      begin
         lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
         mem_ack <= 1'b0;
         // moving junk outside acks so stale data never looks valid
         mem_rdata <= ~mem_rdata ^ {24'h0, lfsr};
         if (mem_req && !mem_ack)
         begin
            if (wait_n == 2'h0)
            begin
               mem_ack <= 1'b1;
               wait_n <= lfsr[1:0];
               if (!mem_we)
                  mem_rdata <= mem_size == 2'h0 ? {24'h0, v[7:0]} :
                               mem_size == 2'h1 ? {16'h0, v[15:0]} : v;
            end
            else
               wait_n <= wait_n - 2'h1;
         end
      end
   end
endmodule // tcd_mem_model
